/* File: logic/io_channel_controller.sv */
// Channel controller: status, connect, list and data channels sharing memory ports.
// Assumes memory ports hold an access until they acknowledge it for one cycle.
`default_nettype none

module io_channel_controller #(
  parameter int NUM_PORTS = 8,
  parameter int NUM_STATUS = 8,
  parameter int NUM_DATA = 8,
  parameter int ADDR_W = 24,
  parameter int FIFO_DEPTH = 16,
  parameter logic [23:0] MAILBOX_BASE = 24'h000400,
  parameter logic [23:0] INT_CELL_ADDR = 24'h000200
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic connectValid,
  input wire logic [1:0] connectSel,
  input wire logic setupValid,
  input wire logic [$clog2(NUM_DATA)-1:0] setupIndex,
  input wire logic setupDirect,
  input wire logic setupWide,
  input wire logic setupSingle,
  input wire logic setupOutbound,
  input wire logic [2:0] setupStatus,
  input wire logic [ADDR_W-1:0] setupAddr,
  input wire logic charValid,
  input wire logic [$clog2(NUM_DATA)-1:0] charIndex,
  input wire logic [8:0] charData,
  output logic charReady,
  input wire logic [NUM_DATA-1:0] listReq,
  input wire logic statusValid,
  input wire logic [$clog2(NUM_DATA)-1:0] statusIndex,
  input wire logic [35:0] statusWord,
  input wire logic emergencyValid,
  input wire logic [35:0] emergencyWord,
  output logic [NUM_PORTS-1:0] memReq,
  output logic memWrite,
  output logic [ADDR_W-1:0] memAddr,
  output logic [35:0] memWdata,
  input wire logic [NUM_PORTS-1:0] memAck,
  input wire logic [NUM_PORTS*36-1:0] memRdata,
  output logic ccwValid,
  output logic [5:0] ccwChannel,
  output logic [35:0] ccwWord,
  output logic dcwValid,
  output logic [5:0] dcwChannel,
  output logic [35:0] dcwWord
);
  localparam int IDX_W = $clog2(NUM_DATA);
  localparam int W = io_channel_pkg::WORD_W;
  localparam logic [35:0] CW_ONE = 36'h000000001;

  // ----------------------------------------
  // Decoding helpers.
  // ----------------------------------------
  function automatic logic [3:0] firstSet(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 15; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : firstSet

  function automatic logic [NUM_PORTS-1:0] portOf(input logic [ADDR_W-1:0] a);
    int idx;
    idx = int'(a[ADDR_W-1 -: io_channel_pkg::PORT_IDX_W]) % NUM_PORTS;
    return NUM_PORTS'(1) << idx;
  endfunction : portOf

  function automatic logic [ADDR_W-1:0] mboxOf(input logic [5:0] ch);
    return ADDR_W'(MAILBOX_BASE) + ADDR_W'(ch) * ADDR_W'(io_channel_pkg::MAILBOX_WORDS);
  endfunction : mboxOf

  function automatic logic [3:0] charsPer(input logic dir, input logic wide, input logic one);
    logic [3:0] perWord;
    perWord = one ? 4'h1 : (wide ? 4'(io_channel_pkg::CHARS9_PER_WORD)
                                 : 4'(io_channel_pkg::CHARS6_PER_WORD));
    return dir ? 4'(perWord * io_channel_pkg::DIRECT_WORDS) : perWord;
  endfunction : charsPer

  // ----------------------------------------
  // State.
  // ----------------------------------------
  io_channel_pkg::seq_state_t state;
  io_channel_pkg::job_t job;
  logic [IDX_W-1:0] jobIdx;
  logic [5:0] jobChan;
  logic [35:0] cw;
  logic issued;
  logic [2:0] portIdx;
  logic [1:0] accCount;
  logic [NUM_DATA-1:0] cfgDirect;
  logic [NUM_DATA-1:0] cfgWide;
  logic [NUM_DATA-1:0] cfgSingle;
  logic [NUM_DATA-1:0] cfgOut;
  logic [2:0] cfgStatus [NUM_DATA];
  logic [ADDR_W-1:0] cfgAddr [NUM_DATA];
  logic [NUM_STATUS-1:0] stsPend;
  logic [35:0] stsWord [NUM_STATUS];
  logic [2:0] connPend;
  logic [NUM_DATA-1:0] listPend;
  logic [71:0] packBuf [NUM_DATA];
  logic [3:0] packCnt [NUM_DATA];
  logic [NUM_DATA-1:0] packFull;
  logic fifoValid;
  logic fifoReady;
  logic [IDX_W+8:0] fifoData;
  logic [IDX_W-1:0] headIdx;
  logic [8:0] headChar;
  logic ackSel;
  logic [35:0] rdataSel;
  logic lastState;
  logic jobDone;
  logic [ADDR_W-1:0] addrNow;
  logic writeNow;
  logic [35:0] wdataNow;
  io_channel_pkg::seq_state_t next_state;
  logic [15:0] dataVec;
  logic [2:0] stsTarget;
  logic [3:0] pick;

  assign headIdx = fifoData[IDX_W+8:9];
  assign headChar = fifoData[8:0];
  assign fifoReady = !packFull[headIdx];
  assign ackSel = |(memAck & memReq);
  assign rdataSel = memRdata[32'(portIdx) * W +: W];
  assign jobDone = (state != io_channel_pkg::ST_IDLE) && issued && ackSel && lastState;
  assign stsTarget = cfgStatus[statusIndex];
  assign pick = firstSet(dataVec);

  for (genvar i = 0; i < 8; i++) begin : g_vec
    if (i < NUM_DATA) begin : g_on
      assign dataVec[2*i] = listPend[i];
      assign dataVec[2*i+1] = packFull[i];
    end else begin : g_off
      assign dataVec[2*i +: 2] = 2'b00;
    end
  end

  io_char_fifo #(
    .WIDTH(IDX_W + 9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .inValid(charValid),
    .inData({charIndex, charData}),
    .inReady(charReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoReady)
  );

  // ----------------------------------------
  // Access plan for the current state.
  // ----------------------------------------
  always_comb begin
    addrNow = cw[ADDR_W-1:0];
    writeNow = 1'b0;
    wdataNow = '0;
    next_state = io_channel_pkg::ST_IDLE;
    lastState = 1'b0;
    case (state)
      io_channel_pkg::ST_MBOX_RD: begin
        addrNow = mboxOf(jobChan);
        next_state = io_channel_pkg::ST_XFER;
      end
      io_channel_pkg::ST_XFER: begin
        if (job == io_channel_pkg::JOB_DATA && cfgDirect[jobIdx]) begin
          addrNow = cfgAddr[jobIdx];
          writeNow = 1'b1;
          wdataNow = packBuf[jobIdx][71:36];
          next_state = io_channel_pkg::ST_XFER_HI;
        end else begin
          writeNow = (job == io_channel_pkg::JOB_STATUS) || (job == io_channel_pkg::JOB_DATA);
          wdataNow = (job == io_channel_pkg::JOB_STATUS) ? stsWord[jobIdx]
                                                         : packBuf[jobIdx][35:0];
          next_state = io_channel_pkg::ST_MBOX_WR;
        end
      end
      io_channel_pkg::ST_XFER_HI: begin
        addrNow = cfgAddr[jobIdx] + ADDR_W'(1);
        writeNow = 1'b1;
        wdataNow = packBuf[jobIdx][35:0];
        lastState = 1'b1;
      end
      io_channel_pkg::ST_MBOX_WR: begin
        addrNow = mboxOf(jobChan);
        writeNow = 1'b1;
        wdataNow = cw + io_channel_pkg::CW_STEP;
        if (job == io_channel_pkg::JOB_STATUS) begin
          next_state = io_channel_pkg::ST_INT_WR;
        end else begin
          lastState = 1'b1;
        end
      end
      io_channel_pkg::ST_INT_WR: begin
        addrNow = ADDR_W'(INT_CELL_ADDR);
        writeNow = 1'b1;
        wdataNow = CW_ONE << jobIdx;
        lastState = 1'b1;
      end
      default: begin
        next_state = io_channel_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer and memory port.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= io_channel_pkg::ST_IDLE;
      job <= io_channel_pkg::JOB_STATUS;
      jobIdx <= '0;
      jobChan <= '0;
      cw <= '0;
      issued <= 1'b0;
      portIdx <= '0;
      memReq <= '0;
      memWrite <= 1'b0;
      memAddr <= '0;
      memWdata <= '0;
    end else if (state == io_channel_pkg::ST_IDLE) begin
      // Status channels first, then connect, then list and data, lowest number first.
      if (|stsPend) begin
        job <= io_channel_pkg::JOB_STATUS;
        jobIdx <= IDX_W'(firstSet(16'(stsPend)));
        jobChan <= 6'(firstSet(16'(stsPend)));
        state <= io_channel_pkg::ST_MBOX_RD;
      end else if (|connPend) begin
        job <= io_channel_pkg::JOB_CONNECT;
        jobChan <= io_channel_pkg::CONNECT_FIRST + 6'(firstSet(16'(connPend)));
        state <= io_channel_pkg::ST_MBOX_RD;
      end else if (|dataVec) begin
        job <= pick[0] ? io_channel_pkg::JOB_DATA : io_channel_pkg::JOB_LIST;
        jobIdx <= IDX_W'(pick >> 1);
        jobChan <= io_channel_pkg::LIST_FIRST + 6'(pick);
        if (pick[0] && cfgDirect[IDX_W'(pick >> 1)]) begin
          state <= io_channel_pkg::ST_XFER;
        end else begin
          state <= io_channel_pkg::ST_MBOX_RD;
        end
      end
    end else if (!issued) begin
      memReq <= portOf(addrNow);
      portIdx <= 3'(firstSet(16'(portOf(addrNow))));
      memAddr <= addrNow;
      memWrite <= writeNow;
      memWdata <= wdataNow;
      issued <= 1'b1;
    end else if (ackSel) begin
      memReq <= '0;
      issued <= 1'b0;
      state <= next_state;
      if (state == io_channel_pkg::ST_MBOX_RD) begin
        cw <= rdataSel;
      end
    end
  end

  // ----------------------------------------
  // Delivery of fetched command and data control words.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      ccwValid <= 1'b0;
      ccwChannel <= '0;
      ccwWord <= '0;
      dcwValid <= 1'b0;
      dcwChannel <= '0;
      dcwWord <= '0;
    end else begin
      ccwValid <= 1'b0;
      dcwValid <= 1'b0;
      if (state == io_channel_pkg::ST_XFER && issued && ackSel) begin
        if (job == io_channel_pkg::JOB_CONNECT) begin
          ccwValid <= 1'b1;
          ccwChannel <= rdataSel[5:0];
          ccwWord <= rdataSel;
        end
        if (job == io_channel_pkg::JOB_LIST) begin
          dcwValid <= 1'b1;
          dcwChannel <= jobChan + 6'h01;
          dcwWord <= rdataSel;
        end
      end
    end
  end

  // ----------------------------------------
  // Pending requests.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stsPend <= '0;
      connPend <= '0;
      listPend <= '0;
    end else begin
      for (int k = 0; k < NUM_STATUS; k++) begin
        if (jobDone && job == io_channel_pkg::JOB_STATUS && jobIdx == IDX_W'(k)) begin
          stsPend[k] <= 1'b0;
        end
        if ((emergencyValid && k == 0) ||
            (statusValid && stsTarget == 3'(k) && !(emergencyValid && k == 0))) begin
          stsPend[k] <= 1'b1;
        end
      end
      for (int k = 0; k < io_channel_pkg::CONNECT_COUNT; k++) begin
        if (jobDone && job == io_channel_pkg::JOB_CONNECT &&
            jobChan == io_channel_pkg::CONNECT_FIRST + 6'(k)) begin
          connPend[k] <= 1'b0;
        end
        if (connectValid && connectSel == 2'(k)) begin
          connPend[k] <= 1'b1;
        end
      end
      for (int k = 0; k < NUM_DATA; k++) begin
        if (jobDone && job == io_channel_pkg::JOB_LIST && jobIdx == IDX_W'(k)) begin
          listPend[k] <= 1'b0;
        end
        if (listReq[k]) begin
          listPend[k] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Status words held until stored.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int k = 0; k < NUM_STATUS; k++) begin
        stsWord[k] <= '0;
      end
    end else begin
      if (statusValid && int'(stsTarget) < NUM_STATUS) begin
        stsWord[stsTarget] <= statusWord;
      end
      if (emergencyValid) begin
        stsWord[0] <= emergencyWord;
      end
    end
  end

  // ----------------------------------------
  // Channel setup and direct control words.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfgDirect <= '0;
      cfgWide <= '0;
      cfgSingle <= '0;
      cfgOut <= '0;
      for (int k = 0; k < NUM_DATA; k++) begin
        cfgStatus[k] <= '0;
        cfgAddr[k] <= '0;
      end
    end else begin
      if (jobDone && job == io_channel_pkg::JOB_DATA && cfgDirect[jobIdx]) begin
        cfgAddr[jobIdx] <= cfgAddr[jobIdx] + ADDR_W'(io_channel_pkg::DIRECT_WORDS);
      end
      if (dcwValid && cfgDirect[jobIdx]) begin
        cfgAddr[jobIdx] <= dcwWord[ADDR_W-1:0];
      end
      if (setupValid) begin
        cfgDirect[setupIndex] <= setupDirect;
        cfgWide[setupIndex] <= setupWide;
        cfgSingle[setupIndex] <= setupSingle;
        cfgOut[setupIndex] <= setupOutbound;
        cfgStatus[setupIndex] <= setupStatus;
        cfgAddr[setupIndex] <= setupAddr;
      end
    end
  end

  // ----------------------------------------
  // Character packing per data channel.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      packFull <= '0;
      for (int k = 0; k < NUM_DATA; k++) begin
        packBuf[k] <= '0;
        packCnt[k] <= '0;
      end
    end else begin
      if (jobDone && job == io_channel_pkg::JOB_DATA) begin
        packFull[jobIdx] <= 1'b0;
        packCnt[jobIdx] <= '0;
      end
      if (fifoValid && fifoReady && !cfgOut[headIdx]) begin
        packBuf[headIdx] <= (packBuf[headIdx] << (cfgSingle[headIdx] ? W :
          (cfgWide[headIdx] ? io_channel_pkg::CHAR9_BITS : io_channel_pkg::CHAR6_BITS))) |
          72'(cfgWide[headIdx] || cfgSingle[headIdx] ? headChar : {3'h0, headChar[5:0]});
        packCnt[headIdx] <= packCnt[headIdx] + 4'h1;
        if (packCnt[headIdx] + 4'h1 ==
            charsPer(cfgDirect[headIdx], cfgWide[headIdx], cfgSingle[headIdx])) begin
          packFull[headIdx] <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn || state == io_channel_pkg::ST_IDLE) begin
      accCount <= '0;
    end else if (issued && ackSel) begin
      accCount <= accCount + 2'h1;
    end
  end

  chk_port_select: assert property (@(posedge clock) disable iff (!resetn)
    (memReq != '0) |-> (memReq == portOf(memAddr) && $onehot(memReq)))
    else $error("memory request on wrong port");

  chk_port_count: assert property (@(posedge clock) disable iff (!resetn)
    NUM_PORTS >= 1 && NUM_PORTS <= io_channel_pkg::MAX_PORTS)
    else $error("port count out of range");

  chk_status_first: assert property (@(posedge clock) disable iff (!resetn)
    (state == io_channel_pkg::ST_IDLE && stsPend[0]) |=>
      (job == io_channel_pkg::JOB_STATUS && jobIdx == '0 && state == io_channel_pkg::ST_MBOX_RD))
    else $error("status channel 0 not served first");

  chk_indirect_three: assert property (@(posedge clock) disable iff (!resetn)
    (jobDone && job == io_channel_pkg::JOB_DATA && !cfgDirect[jobIdx]) |->
      accCount == 2'(io_channel_pkg::INDIRECT_ACCESSES - 1))
    else $error("indirect transfer not three accesses");

  chk_direct_nombox: assert property (@(posedge clock) disable iff (!resetn)
    (job == io_channel_pkg::JOB_DATA && cfgDirect[jobIdx]) |->
      state != io_channel_pkg::ST_MBOX_RD && state != io_channel_pkg::ST_MBOX_WR)
    else $error("direct channel touched its mailbox");

  chk_mailbox_addr: assert property (@(posedge clock) disable iff (!resetn)
    (state == io_channel_pkg::ST_MBOX_RD && $rose(issued)) |->
      (memAddr == mboxOf(jobChan) && !memWrite))
    else $error("mailbox address wrong");

  chk_interrupt_cell: assert property (@(posedge clock) disable iff (!resetn)
    (jobDone && job == io_channel_pkg::JOB_STATUS) |->
      (memAddr == ADDR_W'(INT_CELL_ADDR) && memWrite && $past(state, 2) != io_channel_pkg::ST_IDLE))
    else $error("interrupt cell not set after status");

  chk_dcw_channel: assert property (@(posedge clock) disable iff (!resetn)
    dcwValid |-> (dcwChannel[0] && dcwChannel > io_channel_pkg::LIST_FIRST))
    else $error("data control word for even channel");
endmodule : io_channel_controller

`default_nettype wire

/* File: logic/io_channel_pkg.sv */
// Constants, state and job codes shared by the channel controller files.
// Assumes one clock and a synchronous active-low reset in every user.
`default_nettype none

package io_channel_pkg;
  localparam int WORD_W = 36;
  localparam int CHAN_W = 6;
  localparam int CHAR_W = 9;
  localparam int PORT_IDX_W = 3;
  localparam int MAX_PORTS = 8;
  localparam int MAX_STATUS = 8;
  localparam int MIN_STATUS = 4;
  localparam logic [5:0] CONNECT_FIRST = 6'h08;
  localparam int CONNECT_COUNT = 3;
  localparam logic [5:0] LIST_FIRST = 6'h10;
  localparam int MAILBOX_WORDS = 2;
  localparam int CHAR6_BITS = 6;
  localparam int CHAR9_BITS = 9;
  localparam int CHARS6_PER_WORD = 6;
  localparam int CHARS9_PER_WORD = 4;
  localparam int DIRECT_WORDS = 2;
  localparam int DIRECT_ACCESS_CHARS = 12;
  localparam int INDIRECT_ACCESSES = 3;
  localparam longint CLOCK_HZ = 100000000;
  localparam longint DIRECT_RATE_CPS = 400000;
  localparam int DIRECT_CHAR_CYCLES = int'(CLOCK_HZ / DIRECT_RATE_CPS);
  localparam logic [35:0] CW_STEP = 36'h000000001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MBOX_RD = 3'b001,
    ST_XFER = 3'b011,
    ST_XFER_HI = 3'b111,
    ST_MBOX_WR = 3'b010,
    ST_INT_WR = 3'b110
  } seq_state_t;

  typedef enum logic [1:0] {
    JOB_STATUS = 2'h0,
    JOB_CONNECT = 2'h1,
    JOB_LIST = 2'h2,
    JOB_DATA = 2'h3
  } job_t;
endpackage : io_channel_pkg

`default_nettype wire

/* File: logic/io_char_fifo.sv */
// Character FIFO between the adapter side and the word packers.
// Assumes one clock; the drain side may stall for as long as it likes.
`default_nettype none

module io_char_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [PTR_W:0] count;
  logic push;
  logic pop;
  logic [PTR_W:0] next_count;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outValid = (count != '0);
  assign outData = store[rdPtr];
  assign next_count = count + (PTR_W + 1)'(push) - (PTR_W + 1)'(pop);

  // ----------------------------------------
  // Pointers and fill level.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= next_count;
      inReady <= (next_count < (PTR_W + 1)'(DEPTH));
    end
  end

  // ----------------------------------------
  // Storage.
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (push) begin
      store[wrPtr] <= inData;
    end
  end
endmodule : io_char_fifo

`default_nettype wire

/* File: dv/io_mem_model.sv */
// Memory module model answering every controller port, prompt and slow in turn.
// Assumes one-hot requests held until acknowledged.
`default_nettype none

module io_mem_model #(
  parameter int NP = 8
) (
  input wire logic clock,
  input wire logic [NP-1:0] memReq,
  input wire logic memWrite,
  input wire logic [23:0] memAddr,
  input wire logic [35:0] memWdata,
  output logic [NP-1:0] memAck,
  output logic [NP*36-1:0] memRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] mem [logic [23:0]];
  int waitN = 0;
  int slow = 0;
  int accesses = 0;
  int portErrs = 0;
  initial memAck = '0;
  initial memRdata = '0;
  always @(posedge clock) begin
    if (memAck != '0 || memReq == '0) begin
      memAck <= '0;
      memRdata <= ~memRdata;
      waitN = 0;
    end else if (waitN != slow) begin
      memRdata <= ~memRdata;
      waitN++;
    end else begin
      if (memReq !== NP'(1) << (memAddr[23:21] % NP)) portErrs++;
      memAck <= memReq;
      accesses++;
      slow = 3 - slow;
      if (memWrite) mem[memAddr] = memWdata;
      memRdata <= memWrite ? ~memRdata : {NP{mem[memAddr]}};
    end
  end
endmodule : io_mem_model

`default_nettype wire

/* File: dv/io_channel_controller_test.sv */
// Self-checking bench for the channel controller with a memory model on all ports.
// Assumes default parameters and one clock.
`default_nettype none

module io_channel_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] MB = 24'h000400;
  localparam logic [23:0] ICELL = 24'h000200;
  logic clock = 0, resetn = 0, connectValid = 0, setupValid = 0, setupDirect = 0;
  logic setupWide = 0, setupSingle = 0, setupOutbound = 0, charValid = 0;
  logic statusValid = 0, emergencyValid = 0, charReady, memWrite, ccwValid, dcwValid;
  logic [1:0] connectSel = 0;
  logic [2:0] setupIndex = 0, setupStatus = 0, charIndex = 0, statusIndex = 0;
  logic [23:0] setupAddr = 0, memAddr;
  logic [8:0] charData = 0;
  logic [7:0] listReq = 0, memReq, memAck;
  logic [35:0] statusWord = 0, emergencyWord = 0, memWdata, ccwWord, dcwWord, ccwW, dcwW;
  logic [287:0] memRdata;
  logic [5:0] ccwChannel, dcwChannel, ccwC, dcwC;
  int nErrors = 0, numChecks = 0, mark = 0;

  io_channel_controller #(.MAILBOX_BASE(MB), .INT_CELL_ADDR(ICELL)) u_dut (
    .clock, .resetn, .connectValid, .connectSel, .setupValid, .setupIndex, .setupDirect,
    .setupWide, .setupSingle, .setupOutbound, .setupStatus, .setupAddr, .charValid,
    .charIndex, .charData, .charReady, .listReq, .statusValid, .statusIndex, .statusWord,
    .emergencyValid, .emergencyWord, .memReq, .memWrite, .memAddr, .memWdata, .memAck,
    .memRdata, .ccwValid, .ccwChannel, .ccwWord, .dcwValid, .dcwChannel, .dcwWord);
  io_mem_model u_mem (.clock, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata);

  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    if (ccwValid === 1'b1) begin
      ccwW <= ccwWord;
      ccwC <= ccwChannel;
    end
    if (dcwValid === 1'b1) begin
      dcwW <= dcwWord;
      dcwC <= dcwChannel;
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    numChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic job(input int n);
    int t;
    t = 0;
    while (u_mem.accesses - mark < n) begin
      @(negedge clock);
      t++;
      if (t > 500) begin
        nErrors++;
        end_sim();
      end
    end
    repeat (20) @(negedge clock);
    chk(36'(u_mem.accesses - mark), 36'(n));
  endtask : job

  task automatic setup(input logic [2:0] idx, input logic dir, input logic [23:0] a);
    setupValid = 1;
    setupIndex = idx;
    setupDirect = dir;
    setupStatus = 3'h3;
    setupAddr = a;
    @(negedge clock);
    setupValid = 0;
  endtask : setup

  task automatic send(input logic [2:0] idx, input int n);
    int t;
    charIndex = idx;
    for (int k = 1; k <= n; k++) begin
      charValid = 1;
      charData = 9'(k);
      t = 0;
      while (charReady !== 1'b1) begin
        @(negedge clock);
        t++;
        if (t > 100) begin
          nErrors++;
          end_sim();
        end
      end
      @(negedge clock);
    end
    charValid = 0;
  endtask : send

  task automatic do_connect();
    logic [35:0] p;
    logic [35:0] w;
    for (int n = 0; n < 3; n++) begin
      p = 36'h000a00100 + 36'(16 * n);
      w = 36'h7abc00011 + 36'(n << 8);
      u_mem.mem[MB + 24'(16 + 2 * n)] = p;
      u_mem.mem[p[23:0]] = w;
      mark = u_mem.accesses;
      connectSel = 2'(n);
      connectValid = 1;
      @(negedge clock);
      connectValid = 0;
      job(3);
      chk(ccwW, w);
      chk(36'(ccwC), 36'h11);
      chk(u_mem.mem[MB + 24'(16 + 2 * n)], p + 36'h1);
    end
  endtask : do_connect

  task automatic do_status();
    u_mem.mem[MB] = 36'h000c00000;
    u_mem.mem[MB + 24'h6] = 36'h000e00040;
    setup(3'h1, 1'b0, 24'h0);
    mark = u_mem.accesses;
    emergencyValid = 1;
    emergencyWord = 36'h5a5a5a5a5;
    statusValid = 1;
    statusIndex = 3'h1;
    statusWord = 36'h123456789;
    @(negedge clock);
    emergencyValid = 0;
    statusValid = 0;
    job(8);
    chk(u_mem.mem[24'hc00000], 36'h5a5a5a5a5);
    chk(u_mem.mem[24'he00040], 36'h123456789);
    chk(u_mem.mem[MB + 24'h6], 36'h000e00041);
    chk(u_mem.mem[ICELL], 36'h8);
  endtask : do_status

  task automatic do_list();
    u_mem.mem[MB + 24'd40] = 36'h000600200;
    u_mem.mem[24'h600200] = 36'h000f0f0f0;
    mark = u_mem.accesses;
    listReq = 8'h04;
    @(negedge clock);
    listReq = 8'h00;
    job(3);
    chk(dcwW, 36'h000f0f0f0);
    chk(36'(dcwC), 36'd21);
  endtask : do_list

  task automatic do_data();
    u_mem.mem[MB + 24'd34] = 36'h000200300;
    setup(3'h0, 1'b0, 24'h0);
    mark = u_mem.accesses;
    send(3'h0, 6);
    job(3);
    chk(u_mem.mem[24'h200300], {6'd1, 6'd2, 6'd3, 6'd4, 6'd5, 6'd6});
    chk(u_mem.mem[MB + 24'd34], 36'h000200301);
    setup(3'h3, 1'b1, 24'h800400);
    mark = u_mem.accesses;
    send(3'h3, 12);
    job(2);
    chk(u_mem.mem[24'h800400], {6'd1, 6'd2, 6'd3, 6'd4, 6'd5, 6'd6});
    chk(u_mem.mem[24'h800401], {6'd7, 6'd8, 6'd9, 6'd10, 6'd11, 6'd12});
    u_mem.mem[MB + 24'd38] = 36'h000200400;
    setupWide = 1;
    setup(3'h1, 1'b0, 24'h0);
    setupWide = 0;
    mark = u_mem.accesses;
    send(3'h1, 4);
    job(3);
    chk(u_mem.mem[24'h200400], {9'd1, 9'd2, 9'd3, 9'd4});
    u_mem.mem[MB + 24'd50] = 36'h000200500;
    setupSingle = 1;
    setup(3'h4, 1'b0, 24'h0);
    setupSingle = 0;
    mark = u_mem.accesses;
    send(3'h4, 1);
    job(3);
    chk(u_mem.mem[24'h200500], 36'h000000001);
    setupOutbound = 1;
    setup(3'h2, 1'b0, 24'h0);
    setupOutbound = 0;
    mark = u_mem.accesses;
    send(3'h2, 6);
    job(0);
  endtask : do_data

  initial begin
    repeat (2) @(negedge clock);
    resetn = 1;
    @(negedge clock);
    do_connect();
    do_status();
    do_list();
    do_data();
    chk(36'(u_mem.portErrs), 36'h0);
    end_sim();
  end
endmodule : io_channel_controller_test

`default_nettype wire
